// ### design/flash_seq_pkg.sv
/*
  Shared constants and types for the flash command sequencer: opcodes,
  wrap setting layout, reset values, program timing and the word that
  leaves the page buffer for the cell array.
  Assumes a 10 MHz system clock.
*/
package flash_seq_pkg;

  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_WRAP_SET     = 8'h77;
  localparam logic [7:0] OPC_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OPC_QUAD_PROGRAM = 8'h32;

  // Wrap setting kept as {length[1:0], disable}, from bits 6..4 of the wrap byte
  localparam int          WRAP_FIELD_LO  = 4;
  localparam int          WRAP_FIELD_HI  = 6;
  localparam int          WRAP_DIS_POS   = 0;
  localparam logic [2:0]  WRAP_RESET     = 3'h1;

  localparam int          ADDR_BYTES     = 3;
  localparam logic [1:0]  ADDR_LAST      = 2'h2;
  localparam int          PAGE_BYTES     = 256;
  localparam int          FIFO_DEPTH     = 8;

  localparam int          CLK_HZ         = 10_000_000;
  localparam int          PROG_TIME_US   = 700;
  localparam int          PROG_CYCLES    = (PROG_TIME_US * (CLK_HZ / 1_000_000));

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OPC  = 3'h1,
    ST_ADDR = 3'h3,
    ST_DATA = 3'h2,
    ST_TAIL = 3'h6,
    ST_SKIP = 3'h7
  } link_state_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  data;
  } prog_word_t;

endpackage

// ### design/word_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty without a counter
  assign out_valid_o = (wr_q != rd_q);
  assign in_ready_o  = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_q[AW-1:0]];

  always_ff @(posedge sys_clk_i)
  begin
    if (push)
    begin
      mem[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  fill_bound_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (wr_q - rd_q) <= (AW+1)'(DEPTH))
    else $error("fifo fill beyond depth");

endmodule

// ### design/flash_seq.sv
/*
  Serial flash command sequencer: wrap configuration, write enable,
  single and quad page program with page buffer, self-timed program cycle.
  Assumes chip select, serial clock and the four IO lines come from an
  outside host and are slow against the system clock (8+ cycles per bit).
*/
// What this block does
// - Wrapped quad reads step inside the aligned section and return to its start.
// - Wrap byte bit 4 low enables wrap; bits 6..5 pick 8/16/32/64 bytes.
// - Frame 77h, 24 dummy bits, wrap byte, chip select high latches setting.
// - Stored wrap setting governs all later quad I/O reads outside four-line mode until disabled again.
// - In four-line mode only burst-wrap reads wrap; C0h may change length.
// - Write enable command sets the latch before any program command.
// - Page program is 02h, three address bytes, data bytes, on line zero.
// - Data past page end continues from offset zero of same page.
// - More than 256 bytes: only the last 256 received are programmed.
// - Fewer than 256 bytes: only addressed bytes are programmed.
// - Program runs only if chip select rises on a complete byte boundary.
// - Valid chip select rise starts the timed program cycle at once.
// - Write-in-progress is one during the cycle, zero when complete.
// - Write enable latch clears no later than the cycle end.
// - Program aimed at a protected page is refused.
// - Quad program is 32h, data on four lines, needs quad enable.
// - Incoming bits are sampled on serial clock rising edges.
module flash_seq #(
  parameter int PROG_CYCLES = flash_seq_pkg::PROG_CYCLES
) (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_b_i,
  input  wire logic                      cs_b_i,
  input  wire logic                      sclk_i,
  input  wire logic [3:0]                quad_line_i,
  input  wire logic                      quad_enable_i,
  input  wire logic [4:0]                block_protect_bits_i,
  input  wire logic                      four_line_command_mode_i,
  input  wire logic                      param_len_wr_i,
  input  wire logic [1:0]                param_len_i,
  input  wire logic                      rd_load_i,
  input  wire logic [23:0]               rd_start_addr_i,
  input  wire logic                      rd_step_i,
  input  wire logic                      rd_quad_io_i,
  input  wire logic                      rd_burst_wrap_i,
  output logic                           write_in_progress_o,
  output logic                           write_enable_latch_o,
  output logic [2:0]                     wrap_setting_bits_o,
  output logic [23:0]                    rd_addr_o,
  output logic                           prog_valid_o,
  input  wire logic                      prog_ready_i,
  output flash_seq_pkg::prog_word_t      prog_word_o
);

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  function automatic logic is_protected(input logic [7:0] blk, input logic [4:0] bp);
    logic [8:0] span;
    span = 9'h1 << (bp[2:0] - 3'h1);
    if (bp[2:0] == 3'h0)
      return 1'b0;
    if (bp[4])
      return 1'b1;
    if (bp[3])
      return ({1'b0, blk} < span);
    return ({1'b0, blk} >= (9'h100 - span));
  endfunction

  function automatic logic [23:0] next_rd_addr(input logic [23:0] a, input logic wrap, input logic [1:0] len);
    logic [23:0] m;
    logic [23:0] inc;
    m   = {16'h0000, 8'h07 << len} | 24'h000007;
    m   = {16'h0000, (8'h08 << len) - 8'h01};
    inc = a + 24'h000001;
    if (wrap)
      return (a & ~m) | (inc & m);
    return inc;
  endfunction

  // Synchronisers for the host pins
  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  logic       sclk_prev_q;
  logic       cs_prev_q;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      pin_s1_q <= 6'h20;
      pin_s2_q <= 6'h20;
    end
    else
    begin
      pin_s1_q <= {cs_b_i, sclk_i, quad_line_i};
      pin_s2_q <= pin_s1_q;
    end
  end

  logic       cs_b_s;
  logic       sclk_s;
  logic [3:0] lines_s;
  assign cs_b_s  = pin_s2_q[5];
  assign sclk_s  = pin_s2_q[4];
  assign lines_s = pin_s2_q[3:0];

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
    end
    else
    begin
      sclk_prev_q <= sclk_s;
      cs_prev_q   <= cs_b_s;
    end
  end

  flash_seq_pkg::link_state_t st_q;
  logic [7:0]  opc_q;
  logic [7:0]  shift_q;
  logic [2:0]  bit_cnt_q;
  logic [1:0]  addr_cnt_q;
  logic [23:0] addr_q;
  logic [7:0]  off_q;
  logic        data_seen_q;
  logic        wel_q;
  logic        wip_q;
  logic [2:0]  wrap_q;
  logic [31:0] timer_q;
  logic [8:0]  scan_q;
  localparam int PAGE_MASK_W = flash_seq_pkg::PAGE_BYTES;
  logic [PAGE_MASK_W-1:0] mask_q;
  logic [7:0]  page_mem [flash_seq_pkg::PAGE_BYTES];

  logic        cs_rise;
  logic        edge_act;
  logic        quad_data;
  logic        byte_done;
  logic [7:0]  byte_val;
  logic        is_prog_opc;
  logic        aligned;
  logic        prog_ok;
  logic        write_enable_cmd_ok;
  logic        wrap_ok;
  logic        prog_done;
  logic        fifo_ready;
  logic        scan_valid;

  assign cs_rise     = cs_b_s && !cs_prev_q;
  // Bits count only on a rising serial clock inside an open frame
  assign edge_act    = sclk_s && !sclk_prev_q && !cs_b_s && (st_q != flash_seq_pkg::ST_IDLE);
  assign is_prog_opc = (opc_q == flash_seq_pkg::OPC_PAGE_PROGRAM) || (opc_q == flash_seq_pkg::OPC_QUAD_PROGRAM);
  assign quad_data   = (st_q == flash_seq_pkg::ST_DATA) && (opc_q == flash_seq_pkg::OPC_QUAD_PROGRAM);
  assign byte_val    = quad_data ? {shift_q[3:0], lines_s} : {shift_q[6:0], lines_s[0]};
  assign byte_done   = edge_act && (quad_data ? (bit_cnt_q == 3'h4) : (bit_cnt_q == 3'h7));
  assign aligned     = (bit_cnt_q == 3'h0);

  // Frame end checks use the state as it stood before chip select rose
  assign prog_ok = cs_rise && (st_q == flash_seq_pkg::ST_DATA) && aligned && data_seen_q && is_prog_opc
                   && !is_protected(addr_q[23:16], block_protect_bits_i);
  assign write_enable_cmd_ok = cs_rise && (st_q == flash_seq_pkg::ST_TAIL);
  assign wrap_ok = cs_rise && (st_q == flash_seq_pkg::ST_DATA) && aligned && data_seen_q
                   && (opc_q == flash_seq_pkg::OPC_WRAP_SET);

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i || cs_b_s || (st_q == flash_seq_pkg::ST_IDLE))
    begin
      shift_q   <= 8'h00;
      bit_cnt_q <= 3'h0;
    end
    else if (edge_act)
    begin
      shift_q   <= byte_val;
      bit_cnt_q <= bit_cnt_q + (quad_data ? 3'h4 : 3'h1);
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i || cs_b_s)
    begin
      st_q        <= flash_seq_pkg::ST_IDLE;
      data_seen_q <= 1'b0;
      addr_cnt_q  <= 2'h0;
    end
    else if (st_q == flash_seq_pkg::ST_IDLE)
    begin
      st_q        <= flash_seq_pkg::ST_OPC;
      data_seen_q <= 1'b0;
      addr_cnt_q  <= 2'h0;
    end
    else if (edge_act)
    begin
      unique case (st_q)
        flash_seq_pkg::ST_OPC:
        begin
          if (byte_done)
          begin
            unique case (byte_val)
              flash_seq_pkg::OPC_WRITE_ENABLE:
                st_q <= wip_q ? flash_seq_pkg::ST_SKIP : flash_seq_pkg::ST_TAIL;
              flash_seq_pkg::OPC_WRAP_SET:
                st_q <= flash_seq_pkg::ST_ADDR;
              flash_seq_pkg::OPC_PAGE_PROGRAM:
                st_q <= (wel_q && !wip_q) ? flash_seq_pkg::ST_ADDR : flash_seq_pkg::ST_SKIP;
              flash_seq_pkg::OPC_QUAD_PROGRAM:
                st_q <= (wel_q && !wip_q && quad_enable_i) ? flash_seq_pkg::ST_ADDR : flash_seq_pkg::ST_SKIP;
              default:
                st_q <= flash_seq_pkg::ST_SKIP;
            endcase
          end
        end
        flash_seq_pkg::ST_ADDR:
        begin
          if (byte_done)
          begin
            addr_cnt_q <= addr_cnt_q + 2'h1;
            if (addr_cnt_q == flash_seq_pkg::ADDR_LAST)
            begin
              st_q <= flash_seq_pkg::ST_DATA;
            end
          end
        end
        flash_seq_pkg::ST_DATA:
        begin
          if (byte_done)
          begin
            data_seen_q <= 1'b1;
          end
        end
        flash_seq_pkg::ST_TAIL:
          st_q <= flash_seq_pkg::ST_SKIP;
        flash_seq_pkg::ST_SKIP:
          st_q <= flash_seq_pkg::ST_SKIP;
        default:
          st_q <= flash_seq_pkg::ST_SKIP;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      opc_q  <= 8'h00;
      addr_q <= 24'h000000;
      off_q  <= 8'h00;
    end
    else if (byte_done)
    begin
      if (st_q == flash_seq_pkg::ST_OPC)
      begin
        opc_q <= byte_val;
      end
      if (st_q == flash_seq_pkg::ST_ADDR)
      begin
        addr_q <= {addr_q[15:0], byte_val};
        off_q  <= byte_val;
      end
      if (st_q == flash_seq_pkg::ST_DATA)
      begin
        // Eight-bit offset rolls over inside the page
        off_q <= off_q + 8'h01;
      end
    end
  end

  logic buf_write;
  assign buf_write = byte_done && (st_q == flash_seq_pkg::ST_DATA) && is_prog_opc;

  // Later bytes overwrite earlier ones at the same offset, so the last 256 win
  always_ff @(posedge sys_clk_i)
  begin
    if (buf_write)
    begin
      page_mem[off_q] <= byte_val;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      mask_q <= '0;
    end
    else if (byte_done && (st_q == flash_seq_pkg::ST_ADDR) && (addr_cnt_q == flash_seq_pkg::ADDR_LAST)
             && is_prog_opc)
    begin
      mask_q <= '0;
    end
    else if (buf_write)
    begin
      mask_q[off_q] <= 1'b1;
    end
  end

  // Write enable latch: set by its command, cleared as the cycle completes
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      wel_q <= 1'b0;
    end
    else if (write_enable_cmd_ok)
    begin
      wel_q <= 1'b1;
    end
    else if (prog_done)
    begin
      wel_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      wrap_q <= flash_seq_pkg::WRAP_RESET;
    end
    else if (wrap_ok)
    begin
      wrap_q <= shift_q[flash_seq_pkg::WRAP_FIELD_HI:flash_seq_pkg::WRAP_FIELD_LO];
    end
    else if (param_len_wr_i)
    begin
      wrap_q[2:1] <= param_len_i;
    end
  end

  // Program cycle: timer and page scan run side by side; the cycle ends only
  // when both are through, so a slow cell array stretches it
  assign scan_valid = wip_q && !scan_q[8] && mask_q[scan_q[7:0]];
  assign prog_done  = wip_q && (timer_q == 32'h0) && scan_q[8] && !prog_valid_o;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      wip_q   <= 1'b0;
      timer_q <= 32'h0;
      scan_q  <= 9'h100;
    end
    else if (prog_ok)
    begin
      wip_q   <= 1'b1;
      timer_q <= 32'(PROG_CYCLES - 1);
      scan_q  <= 9'h000;
    end
    else if (wip_q)
    begin
      if (timer_q != 32'h0)
      begin
        timer_q <= timer_q - 32'h1;
      end
      if (!scan_q[8] && (!mask_q[scan_q[7:0]] || fifo_ready))
      begin
        scan_q <= scan_q + 9'h001;
      end
      if (prog_done)
      begin
        wip_q <= 1'b0;
      end
    end
  end

  flash_seq_pkg::prog_word_t scan_word;
  flash_seq_pkg::prog_word_t fifo_out;
  assign scan_word.addr = {addr_q[23:8], scan_q[7:0]};
  assign scan_word.data = page_mem[scan_q[7:0]];

  word_fifo #(
    .WIDTH ($bits(flash_seq_pkg::prog_word_t)),
    .DEPTH (flash_seq_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (scan_valid),
    .in_ready_o  (fifo_ready),
    .in_data_i   (scan_word),
    .out_valid_o (prog_valid_o),
    .out_ready_i (prog_ready_i),
    .out_data_o  (fifo_out)
  );
  assign prog_word_o = fifo_out;

  logic wrap_active;
  // Four-line mode wraps only for the dedicated burst read
  assign wrap_active = four_line_command_mode_i ? rd_burst_wrap_i
                       : (rd_quad_io_i && !wrap_q[flash_seq_pkg::WRAP_DIS_POS]);

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      rd_addr_o <= 24'h000000;
    end
    else if (rd_load_i)
    begin
      rd_addr_o <= rd_start_addr_i;
    end
    else if (rd_step_i)
    begin
      rd_addr_o <= next_rd_addr(rd_addr_o, wrap_active, wrap_q[2:1]);
    end
  end

  assign write_in_progress_o  = wip_q;
  assign write_enable_latch_o = wel_q;
  assign wrap_setting_bits_o  = wrap_q;

  wip_start_a: assert property (prog_ok |=> wip_q && (timer_q == 32'(PROG_CYCLES - 1)))
    else $error("program cycle did not start on valid frame end");
  wel_needed_a: assert property ($rose(wip_q) |-> $past(wel_q))
    else $error("program started without write enable latch");
  wel_cleared_a: assert property ($fell(wip_q) |-> !wel_q)
    else $error("write enable latch still set after cycle");
  wip_length_a: assert property ($fell(wip_q) |-> $past(timer_q) == 32'h0)
    else $error("program cycle ended before its time");
  protect_gate_a: assert property ($rose(wip_q) |-> !is_protected($past(addr_q[23:16]), $past(block_protect_bits_i)))
    else $error("program started on protected page");
  byte_align_a: assert property ($rose(wip_q) |-> $past(bit_cnt_q) == 3'h0 && $past(data_seen_q))
    else $error("program started off a byte boundary");
  wrap_latch_a: assert property (wrap_ok |=> wrap_q == $past(shift_q[6:4]))
    else $error("wrap setting not latched from final byte");
  wrap_bound_a: assert property (rd_step_i && !rd_load_i && wrap_active
    |=> (rd_addr_o[23:6] == $past(rd_addr_o[23:6])) && ((rd_addr_o ^ $past(rd_addr_o)) >> (3 + $past(wrap_q[2:1]))) == 0)
    else $error("wrapped read left its section");
  quad_gate_a: assert property ($rose(wip_q) && ($past(opc_q) == flash_seq_pkg::OPC_QUAD_PROGRAM)
    |-> $past(st_q) == flash_seq_pkg::ST_DATA && $past(quad_enable_i))
    else $error("quad program accepted without quad enable");

endmodule

// ### verif/flash_host_model.sv
/*
  Host-side model of the serial flash controller: chip select, serial clock
  and the four IO lines. Assumes each task is entered at a falling edge of
  sys_clk_i; one serial clock period is eight system cycles.
*/
module flash_host_model (
  input  wire logic       sys_clk_i,
  output logic            cs_b_o,
  output logic            sclk_o,
  output logic [3:0]      quad_line_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    cs_b_o      = 1'b1;
    sclk_o      = 1'b0;
    quad_line_o = 4'h5;
  end

  // Lines change only while the clock is low, so they are settled at the rise
  task automatic bit_out(input logic [3:0] v);
    quad_line_o = v;
    repeat (4) @(negedge sys_clk_i);
    sclk_o = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    sclk_o = 1'b0;
  endtask

  task automatic open_frame();
    cs_b_o = 1'b0;
  endtask

  // Unused lines toggle every bit so no stale level can pass for data
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++)
      bit_out({~quad_line_o[3:1], b[7-i]});
  endtask

  task automatic send_quad(input logic [7:0] b);
    bit_out(b[7:4]);
    bit_out(b[3:0]);
  endtask

  task automatic close_frame();
    repeat (4) @(negedge sys_clk_i);
    cs_b_o      = 1'b1;
    quad_line_o = ~quad_line_o;
    repeat (6) @(negedge sys_clk_i);
  endtask
endmodule

// ### verif/tb.sv
/*
  Self-checking bench for the flash command sequencer.
  Assumes the host model drives the link and the bench plays the cell array.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic                      sys_clk, rst_b, cs_b, sclk;
  logic [3:0]                quad_line;
  logic                      qe, four_line, len_wr, rd_load, rd_step;
  logic                      rd_qio, rd_bw, prog_ready, write_in_progress, write_enable_latch, prog_valid;
  logic [4:0]                bp;
  logic [1:0]                len;
  logic [23:0]               rd_start, rd_addr;
  logic [2:0]                wrap_bits;
  flash_seq_pkg::prog_word_t prog_word;
  logic [31:0]               got_q[$];
  logic [7:0]                dat[300];
  int                        n_mismatch, total_checks, cyc;

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  flash_host_model host (.sys_clk_i(sys_clk), .cs_b_o(cs_b), .sclk_o(sclk), .quad_line_o(quad_line));

  flash_seq #(.PROG_CYCLES(20)) u_dut (
    .sys_clk_i(sys_clk), .rst_b_i(rst_b), .cs_b_i(cs_b), .sclk_i(sclk),
    .quad_line_i(quad_line), .quad_enable_i(qe), .block_protect_bits_i(bp),
    .four_line_command_mode_i(four_line), .param_len_wr_i(len_wr), .param_len_i(len),
    .rd_load_i(rd_load), .rd_start_addr_i(rd_start), .rd_step_i(rd_step),
    .rd_quad_io_i(rd_qio), .rd_burst_wrap_i(rd_bw), .write_in_progress_o(write_in_progress),
    .write_enable_latch_o(write_enable_latch), .wrap_setting_bits_o(wrap_bits), .rd_addr_o(rd_addr),
    .prog_valid_o(prog_valid), .prog_ready_i(prog_ready), .prog_word_o(prog_word)
  );

  // The cell array stalls about one cycle in four
  always @(negedge sys_clk)
    prog_ready <= ($urandom % 4) != 0;

  always @(posedge sys_clk)
  begin
    if (rst_b === 1'b1 && prog_valid === 1'b1 && prog_ready === 1'b1)
      got_q.push_back(prog_word);
    cyc++;
    if (cyc == 50000)
    begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk_flag(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Opcode and address always on line zero; tail adds a broken last byte
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int nd, input bit quad, input int tail);
    host.open_frame();
    host.send_bits(op, 8);
    if (nd > 0)
      for (int i = 2; i >= 0; i--)
        host.send_bits(a[8*i +: 8], 8);
    for (int i = 0; i < nd; i++)
      if (quad)
        host.send_quad(dat[i]);
      else
        host.send_bits(dat[i], 8);
    if (tail > 0)
      host.send_bits(8'h5a, tail);
    host.close_frame();
  endtask

  task automatic prog(input logic [7:0] op, input logic [23:0] a, input int nd, input int tail, input bit run);
    logic [7:0] pg[256];
    bit         w[256];
    int         k;
    int         n;
    int         o;
    for (int i = 0; i < nd; i++)
      dat[i] = 8'($urandom);
    got_q.delete();
    cmd(op, a, nd, op == flash_seq_pkg::OPC_QUAD_PROGRAM, tail);
    chk_flag("wip_start", run, write_in_progress);
    n = 0;
    while (write_in_progress !== 1'b0 && n < 3000)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk_flag("wip_done", 1'b0, write_in_progress);
    if (run)
      chk_flag("wel_done", 1'b0, write_enable_latch);
    repeat (4) @(negedge sys_clk);
    // Later bytes overwrite earlier ones at the same offset
    for (int i = 0; i < nd; i++)
    begin
      o = (int'(a[7:0]) + i) % 256;
      pg[o] = dat[i];
      w[o] = 1'b1;
    end
    k = 0;
    for (int j = 0; j < 256; j++)
      if (run && w[j])
      begin
        chk_val("word", {a[23:8], 8'(j), pg[j]}, k < got_q.size() ? got_q[k] : 32'hx);
        k++;
      end
    chk_val("word_count", k, got_q.size());
  endtask

  task automatic rd_run(input bit wr, input logic [1:0] l);
    logic [23:0] a;
    logic [23:0] m;
    a = 24'($urandom);
    m = (24'h8 << l) - 24'h1;
    rd_start = a;
    rd_load = 1'b1;
    @(negedge sys_clk);
    rd_load = 1'b0;
    chk_val("rd_load", a, rd_addr);
    rd_step = 1'b1;
    repeat (70)
    begin
      @(negedge sys_clk);
      a = wr ? ((a & ~m) | ((a + 24'h1) & m)) : a + 24'h1;
      chk_val("rd_addr", a, rd_addr);
    end
    rd_step = 1'b0;
  endtask

  initial
  begin
    {rst_b, qe, four_line, len_wr, rd_load, rd_step, rd_qio, rd_bw, prog_ready} = '0;
    bp = 5'h00;
    len = 2'h0;
    rd_start = 24'h0;
    void'($urandom(57192));
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk_flag("wip_rst", 1'b0, write_in_progress);
    chk_flag("wel_rst", 1'b0, write_enable_latch);
    chk_val("wrap_rst", 3'h1, wrap_bits);
    $display("test reset done");
    prog(flash_seq_pkg::OPC_PAGE_PROGRAM, 24'h00_2040, 4, 0, 0);
    $display("test no_latch done");
    cmd(flash_seq_pkg::OPC_WRITE_ENABLE, 24'h0, 0, 0, 0);
    chk_flag("wel_set", 1'b1, write_enable_latch);
    prog(flash_seq_pkg::OPC_PAGE_PROGRAM, 24'h12_34fc, 6, 0, 1);
    cmd(flash_seq_pkg::OPC_WRITE_ENABLE, 24'h0, 0, 0, 0);
    prog(flash_seq_pkg::OPC_PAGE_PROGRAM, 24'h00_0110, 260, 0, 1);
    $display("test program done");
    cmd(flash_seq_pkg::OPC_WRITE_ENABLE, 24'h0, 0, 0, 0);
    prog(flash_seq_pkg::OPC_PAGE_PROGRAM, 24'h03_0000, 2, 3, 0);
    bp = 5'h11;
    prog(flash_seq_pkg::OPC_PAGE_PROGRAM, 24'h03_0000, 3, 0, 0);
    bp = 5'h00;
    prog(flash_seq_pkg::OPC_QUAD_PROGRAM, 24'h05_0080, 5, 0, 0);
    chk_flag("wel_kept", 1'b1, write_enable_latch);
    qe = 1'b1;
    prog(flash_seq_pkg::OPC_QUAD_PROGRAM, 24'h05_00fe, 5, 0, 1);
    $display("test refusals done");
    rd_qio = 1'b1;
    for (int l = 0; l < 4; l++)
    begin
      dat[0] = {1'($urandom), 2'(l), 1'b0, 4'($urandom)};
      cmd(flash_seq_pkg::OPC_WRAP_SET, 24'($urandom), 1, 0, 0);
      chk_val("wrap", dat[0][6:4], wrap_bits);
      rd_run(1'b1, 2'(l));
    end
    four_line = 1'b1;
    rd_run(1'b0, 2'h0);
    rd_bw = 1'b1;
    rd_run(1'b1, 2'h3);
    len = 2'h2;
    len_wr = 1'b1;
    @(negedge sys_clk);
    len_wr = 1'b0;
    chk_val("wrap_param", 3'h4, wrap_bits);
    rd_run(1'b1, 2'h2);
    {four_line, rd_bw} = 2'b00;
    dat[0] = {3'($urandom), 1'b1, 4'($urandom)};
    cmd(flash_seq_pkg::OPC_WRAP_SET, 24'h0, 1, 0, 0);
    chk_val("wrap_off", dat[0][6:4], wrap_bits);
    rd_run(1'b0, 2'h0);
    $display("test wrap done");
    results();
  end
endmodule
